/* File: core/dch_pkg.sv */
// Shared constants and types for the detector calibration command handler
package dch_pkg;
	// ==================== Register map ====================
	localparam logic [7:0] REG_CMD      = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_MULT_ERR = 8'h08;
	localparam logic [7:0] REG_BIAS_ACT = 8'h0c;
	localparam logic [7:0] REG_QUERY    = 8'h10;
	localparam logic [7:0] REG_OFS_SEL  = 8'h14;
	localparam logic [7:0] REG_OFS_DATA = 8'h18;
	localparam logic [7:0] REG_DET      = 8'h1c;

	// ==================== Command word fields ====================
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_FORM_LSB = 4;
	localparam int CMD_NONINT   = 6;
	localparam int CMD_VAL_LSB  = 16;

	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_CAL_ALL = 3'h1;
	localparam logic [2:0] OP_FULL_CAL = 3'h2;
	localparam logic [2:0] OP_BIAS = 3'h3;
	localparam logic [2:0] OP_OPTION = 3'h4;

	localparam logic [1:0] FORM_BARE = 2'h0;
	localparam logic [1:0] FORM_VALUE = 2'h1;
	localparam logic [1:0] FORM_DEFAULT = 2'h2;
	localparam logic [1:0] FORM_QUERY = 2'h3;

	typedef struct packed {
		logic [11:0] value;
		logic        nonInteger;
		logic [1:0]  form;
		logic [2:0]  op;
	} dch_cmd_t;

	// ==================== Bias limits ====================
	localparam logic [11:0] BIAS_MIN     = 12'h00a; // 10 V
	localparam logic [11:0] BIAS_MAX     = 12'h9ba; // 2490 V
	localparam logic [11:0] BIAS_DEFAULT = 12'h578; // 1400 V

	// ==================== Status and error bits ====================
	localparam int STAT_CMD_ERR  = 0;
	localparam int STAT_PARM_ERR = 2;
	localparam int STAT_MULT_ERR = 3;
	localparam int MERR_NO_OPT   = 0;
	localparam int MERR_MISSING  = 1;
	localparam int MERR_RANGE    = 2;
	localparam int MERR_SETTLE   = 3;

	// ==================== Analog engine operations ====================
	localparam logic [1:0] ENG_ZERO = 2'h0;
	localparam logic [1:0] ENG_MASS = 2'h1;
	localparam logic [1:0] ENG_CAL = 2'h2;
	localparam logic [1:0] ENG_SETTLE = 2'h3;

	// ==================== Scan kinds ====================
	localparam logic [1:0] SCAN_ANALOG = 2'h1;
	localparam logic [1:0] SCAN_HIST = 2'h2;
	localparam logic [1:0] SCAN_SINGLE = 2'h3;

	// ==================== Characters ====================
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_ONE = 8'h31;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam int RESP_MAX = 6;
endpackage : dch_pkg

/* File: core/dch_cmd_handler.sv */
// Detector calibration command handler with APB register access
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps

// Overview of operation
// - One zero offset per detector setting; all cleared on full calibration and reset.
// - Analog and histogram scans readjust the detector zero first.
// - Mass axis correction before analog and histogram scans, never single mass.
// - Calibrate-all ends by switching off quadrupole RF and DC.
// - Calibrate-all with any parameter gives bad-parameter error.
// - Full calibration stores table to non-volatile memory; status only at end.
// - Full calibration with any parameter gives bad-parameter error.
// - Bias zero: no bias, Faraday cup, positive mode, indicator off, status.
// - Bias 10..2490: negative bias, multiplier anode, indicator on, status.
// - Current magnitudes are sent in both detector modes.
// - Default token applies 1400 V bias.
// - Bias query returns actual driver output magnitude.
// - Power-on reset selects Faraday cup detection.
// - Bias command without multiplier option gives bad-command error.
// - Bias other than integer 0 or 10..2490 rejected; missing parameter is bad-parameter.
// - Failed bias command sets status bit 3 and records cause byte.
// - Bias indicator always follows the multiplier bias state.
// - Option query answers ASCII 0 or 1 then LF, CR.
// - Option command accepts only query form, else bad-parameter.
// - Bias status byte waits for multiplier and electrometer settling.
module dch_cmd_handler #(
	parameter int SET_W = 4,
	parameter int OFS_W = 16
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              optionPin,
	input  wire logic [SET_W-2:0]  noiseFloor,
	input  wire logic [1:0]        scanReq,
	input  wire logic              scanReqValid,
	output logic                   scanGo,
	output logic [1:0]             engineOp,
	output logic                   engineStart,
	input  wire logic              engineDone,
	input  wire logic              engineFault,
	input  wire logic [OFS_W-1:0]  offsetMeas,
	input  wire logic [11:0]       biasActual,
	output logic                   nvmStore,
	output logic [11:0]            biasSet,
	output logic                   anodeSelect,
	output logic                   negativeMode,
	output logic                   magnitudeMode,
	output logic                   biasIndicator,
	output logic                   rfDcOn,
	output logic [OFS_W-1:0]       offsetCorr,
	output logic [7:0]             txData,
	output logic                   txValid,
	input  wire logic              txReady
);
	typedef enum {ST_IDLE, ST_ZERO, ST_MASS, ST_CAL, ST_SETTLE, ST_SEND}
		dch_state_t;
	localparam int DEPTH = 1 << SET_W;

	// ==================== Helpers ====================
	function automatic logic [7:0] digitChar(input logic [11:0] v,
		input logic [11:0] div);
		logic [11:0] q;
		q = (v / div) % 12'd10;
		digitChar = dch_pkg::CH_ZERO + q[7:0];
	endfunction : digitChar

	// ==================== Input synchronisers ====================
	// Option strap and engine answers come from another domain
	logic [1:0] optSync;
	logic [1:0] doneSync;
	logic [1:0] faultSync;
	logic       doneSeen;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			optSync   <= 2'h0;
			doneSync  <= 2'h0;
			faultSync <= 2'h0;
			doneSeen  <= 1'b0;
		end else begin
			optSync   <= {optSync[0], optionPin};
			doneSync  <= {doneSync[0], engineDone};
			faultSync <= {faultSync[0], engineFault};
			doneSeen  <= doneSync[1];
		end
	end
	logic optionFitted;
	logic donePulse;
	assign optionFitted = optSync[1];
	assign donePulse    = doneSync[1] & ~doneSeen;

	// ==================== APB access ====================
	logic apbWr;
	logic apbRd;
	logic mapped;
	logic busy;
	logic cmdTake;
	assign apbWr = psel & penable & pwrite;
	assign apbRd = psel & penable & ~pwrite;
	assign pready = 1'b1;
	always_comb begin
		case (paddr)
			dch_pkg::REG_CMD, dch_pkg::REG_STATUS, dch_pkg::REG_MULT_ERR,
			dch_pkg::REG_BIAS_ACT, dch_pkg::REG_QUERY, dch_pkg::REG_OFS_SEL,
			dch_pkg::REG_OFS_DATA, dch_pkg::REG_DET: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	// A command while one is in flight is refused, not queued
	assign pslverr = psel & penable &
		(~mapped | (pwrite & paddr == dch_pkg::REG_CMD & busy));
	assign cmdTake = apbWr & paddr == dch_pkg::REG_CMD & ~busy;

	dch_pkg::dch_cmd_t cmd;
	logic              cmdPend;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cmd     <= '0;
			cmdPend <= 1'b0;
		end else if (cmdTake) begin
			cmd.op         <= pwdata[dch_pkg::CMD_OP_LSB +: 3];
			cmd.form       <= pwdata[dch_pkg::CMD_FORM_LSB +: 2];
			cmd.nonInteger <= pwdata[dch_pkg::CMD_NONINT];
			cmd.value      <= pwdata[dch_pkg::CMD_VAL_LSB +: 12];
			cmdPend        <= 1'b1;
		end else if (cmdPend) begin
			cmdPend <= 1'b0;
		end
	end

	// ==================== Command check ====================
	logic [11:0] reqBias;
	logic [7:0]  chkStatus;
	logic [7:0]  chkMerr;
	always_comb begin
		chkStatus = 8'h00;
		chkMerr   = 8'h00;
		reqBias   = (cmd.form == dch_pkg::FORM_DEFAULT) ?
			dch_pkg::BIAS_DEFAULT : cmd.value;
		case (cmd.op)
			dch_pkg::OP_CAL_ALL, dch_pkg::OP_FULL_CAL: begin
				if (cmd.form != dch_pkg::FORM_BARE)
					chkStatus[dch_pkg::STAT_PARM_ERR] = 1'b1;
			end
			dch_pkg::OP_BIAS: begin
				if (!optionFitted) begin
					chkStatus[dch_pkg::STAT_CMD_ERR] = 1'b1;
					chkMerr[dch_pkg::MERR_NO_OPT]    = 1'b1;
				end else if (cmd.form == dch_pkg::FORM_BARE) begin
					chkStatus[dch_pkg::STAT_PARM_ERR] = 1'b1;
					chkMerr[dch_pkg::MERR_MISSING]    = 1'b1;
				end else if (cmd.form == dch_pkg::FORM_VALUE &&
					(cmd.nonInteger || cmd.value > dch_pkg::BIAS_MAX ||
					(cmd.value != 12'h000 && cmd.value < dch_pkg::BIAS_MIN)))
					begin
					chkStatus[dch_pkg::STAT_PARM_ERR] = 1'b1;
					chkMerr[dch_pkg::MERR_RANGE]      = 1'b1;
				end
				if (chkStatus != 8'h00)
					chkStatus[dch_pkg::STAT_MULT_ERR] = 1'b1;
			end
			dch_pkg::OP_OPTION: begin
				if (cmd.form != dch_pkg::FORM_QUERY)
					chkStatus[dch_pkg::STAT_PARM_ERR] = 1'b1;
			end
			default: chkStatus[dch_pkg::STAT_CMD_ERR] = 1'b1;
		endcase
	end

	// ==================== Sequencer ====================
	dch_state_t state;
	logic       forScan;
	logic       scanIdle;
	logic [2:0] txIdx;
	logic [2:0] txLen;
	assign busy     = state != ST_IDLE | cmdPend;
	assign scanIdle = state == ST_IDLE & ~cmdPend & scanReqValid;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state   <= ST_IDLE;
			forScan <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (cmdPend) begin
						forScan <= 1'b0;
						if (chkStatus != 8'h00 || cmd.form == dch_pkg::FORM_QUERY)
							state <= ST_SEND;
						else if (cmd.op == dch_pkg::OP_CAL_ALL)
							state <= ST_ZERO;
						else if (cmd.op == dch_pkg::OP_FULL_CAL)
							state <= ST_CAL;
						else
							state <= ST_SETTLE;
					end else if (scanIdle && scanReq != dch_pkg::SCAN_SINGLE &&
						scanReq != 2'h0) begin
						forScan <= 1'b1;
						state   <= ST_ZERO;
					end
				end
				ST_ZERO: if (donePulse) state <= ST_MASS;
				ST_MASS: if (donePulse) state <= forScan ? ST_IDLE : ST_SEND;
				ST_CAL: if (donePulse) state <= ST_SEND;
				ST_SETTLE: if (donePulse) state <= ST_SEND;
				ST_SEND: if (txValid && txReady && txIdx == txLen) state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Engine request pulses on entry to each waiting state
	dch_state_t prevState;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			prevState <= ST_IDLE;
		else
			prevState <= state;
	end
	logic waiting;
	assign waiting = state == ST_ZERO | state == ST_MASS |
		state == ST_CAL | state == ST_SETTLE;
	assign engineStart = waiting & state != prevState;
	always_comb begin
		case (state)
			ST_MASS: engineOp = dch_pkg::ENG_MASS;
			ST_CAL: engineOp = dch_pkg::ENG_CAL;
			ST_SETTLE: engineOp = dch_pkg::ENG_SETTLE;
			default: engineOp = dch_pkg::ENG_ZERO;
		endcase
	end
	assign nvmStore = state == ST_CAL & donePulse;

	// ==================== Scan trigger and quadrupole drive ====================
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			scanGo <= 1'b0;
		else
			scanGo <= (state == ST_MASS & donePulse & forScan) |
				(scanIdle & scanReq == dch_pkg::SCAN_SINGLE);
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			rfDcOn <= 1'b0;
		else if (state == ST_MASS && donePulse && !forScan)
			rfDcOn <= 1'b0;
		else if (scanGo)
			rfDcOn <= 1'b1;
	end

	// ==================== Offset table ====================
	// Table is volatile, so a power cycle loses every entry
	logic [OFS_W-1:0] ofsMem [DEPTH];
	logic [DEPTH-1:0] ofsValid;
	logic [SET_W-1:0] setIdx;
	logic [SET_W-1:0] ofsSel;
	assign setIdx = {anodeSelect, noiseFloor};
	always_ff @(posedge clk_sys) begin
		if (state == ST_ZERO && donePulse)
			ofsMem[setIdx] <= offsetMeas;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ofsValid <= '0;
		else if (state == ST_CAL && donePulse)
			ofsValid <= '0;
		else if (state == ST_ZERO && donePulse)
			ofsValid[setIdx] <= 1'b1;
	end
	assign offsetCorr = ofsValid[setIdx] ? ofsMem[setIdx] : '0;

	// ==================== Detector configuration ====================
	logic biasApply;
	assign biasApply = state == ST_IDLE & cmdPend & cmd.op == dch_pkg::OP_BIAS &
		chkStatus == 8'h00 & cmd.form != dch_pkg::FORM_QUERY;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			biasSet     <= 12'h000;
			anodeSelect <= 1'b0;
		end else if (biasApply) begin
			biasSet     <= reqBias;
			anodeSelect <= reqBias != 12'h000;
		end
	end
	assign negativeMode  = anodeSelect;
	assign magnitudeMode = 1'b1;
	assign biasIndicator = biasSet != 12'h000;

	// ==================== Status, error and response ====================
	logic [7:0]  statusByte;
	logic [7:0]  multErr;
	logic [11:0] queryVal;
	logic [7:0]  txBuf [dch_pkg::RESP_MAX];
	logic        settleFail;
	assign settleFail = state == ST_SETTLE & donePulse & faultSync[1];
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			statusByte <= 8'h00;
			multErr    <= 8'h00;
		end else if (state == ST_IDLE && cmdPend) begin
			statusByte <= chkStatus;
			if (cmd.op == dch_pkg::OP_BIAS)
				multErr <= chkMerr;
		end else if (settleFail) begin
			statusByte[dch_pkg::STAT_MULT_ERR] <= 1'b1;
			multErr[dch_pkg::MERR_SETTLE]      <= 1'b1;
		end
	end

	// Response bytes are built once, when the command is taken
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			queryVal <= 12'h000;
			txLen    <= 3'h0;
			for (int i = 0; i < dch_pkg::RESP_MAX; i++)
				txBuf[i] <= 8'h00;
		end else if (state == ST_IDLE && cmdPend) begin
			txLen <= 3'h0;
			if (chkStatus == 8'h00 && cmd.op == dch_pkg::OP_OPTION) begin
				txBuf[0] <= optionFitted ? dch_pkg::CH_ONE : dch_pkg::CH_ZERO;
				txBuf[1] <= dch_pkg::CH_LF;
				txBuf[2] <= dch_pkg::CH_CR;
				txLen    <= 3'h2;
			end else if (chkStatus == 8'h00 &&
				cmd.form == dch_pkg::FORM_QUERY) begin
				queryVal <= biasActual;
				txBuf[0] <= digitChar(biasActual, 12'd1000);
				txBuf[1] <= digitChar(biasActual, 12'd100);
				txBuf[2] <= digitChar(biasActual, 12'd10);
				txBuf[3] <= digitChar(biasActual, 12'd1);
				txBuf[4] <= dch_pkg::CH_LF;
				txBuf[5] <= dch_pkg::CH_CR;
				txLen    <= 3'h5;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			txIdx <= 3'h0;
		else if (state != ST_SEND)
			txIdx <= 3'h0;
		else if (txValid && txReady)
			txIdx <= txIdx + 3'h1;
	end
	logic isQuery;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			isQuery <= 1'b0;
		else if (state == ST_IDLE && cmdPend)
			isQuery <= chkStatus == 8'h00 && (cmd.form == dch_pkg::FORM_QUERY);
	end
	// Status only after the sequencer has left every waiting state
	assign txValid = state == ST_SEND;
	always_comb begin
		if (isQuery)
			txData = txBuf[txIdx];
		else
			txData = statusByte;
	end

	// ==================== Register read ====================
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ofsSel <= '0;
		else if (apbWr && paddr == dch_pkg::REG_OFS_SEL)
			ofsSel <= pwdata[SET_W-1:0];
	end
	always_comb begin
		prdata = 32'h0000_0000;
		if (apbRd) begin
			case (paddr)
				dch_pkg::REG_STATUS: prdata = {23'h0, busy, statusByte};
				dch_pkg::REG_MULT_ERR: prdata = {24'h0, multErr};
				dch_pkg::REG_BIAS_ACT: prdata = {20'h0, biasActual};
				dch_pkg::REG_QUERY: prdata = {20'h0, queryVal};
				dch_pkg::REG_OFS_SEL: prdata = {{(32-SET_W){1'b0}}, ofsSel};
				dch_pkg::REG_OFS_DATA: prdata = {{(31-OFS_W){1'b0}},
					ofsValid[ofsSel], ofsMem[ofsSel]};
				dch_pkg::REG_DET: prdata = {17'h0, optionFitted, biasIndicator,
					anodeSelect, biasSet};
				default: prdata = 32'h0000_0000;
			endcase
		end
	end
endmodule : dch_cmd_handler

/* File: testbench/dch_cmd_handler_asserts.sv */
// Port checks for the detector calibration command handler
`timescale 1ns/100ps
module dch_cmd_handler_asserts (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic [1:0]  scanReq,
	input wire logic        scanReqValid,
	input wire logic        scanGo,
	input wire logic [1:0]  engineOp,
	input wire logic        engineStart,
	input wire logic        nvmStore,
	input wire logic        txValid,
	input wire logic [11:0] biasSet,
	input wire logic        anodeSelect,
	input wire logic        negativeMode,
	input wire logic        magnitudeMode,
	input wire logic        biasIndicator
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// ==================== Detector state ====================
	a_ind_follows: assert property (biasIndicator == (biasSet != 12'h000))
		else $error("bias indicator differs from bias");
	a_neg_mode: assert property (negativeMode == anodeSelect)
		else $error("current polarity differs from detector");
	a_mag_mode: assert property (magnitudeMode)
		else $error("magnitude mode dropped");
	a_reset_faraday: assert property (!$past(rst_n) |-> !anodeSelect && !biasIndicator)
		else $error("detector not Faraday after reset");
	// ==================== Sequencing ====================
	a_single_fast: assert property (scanReqValid && scanReq == dch_pkg::SCAN_SINGLE
		|=> scanGo && !engineStart)
		else $error("single scan not immediate");
	a_scan_zero: assert property (scanReqValid && (scanReq == dch_pkg::SCAN_ANALOG
		|| scanReq == dch_pkg::SCAN_HIST) |-> ##[1:2]
		(engineStart && engineOp == dch_pkg::ENG_ZERO))
		else $error("scan without zero step");
	a_nvm_pulse: assert property (nvmStore |-> engineOp == dch_pkg::ENG_CAL ##1 !nvmStore)
		else $error("store pulse malformed");
	a_nvm_status: assert property (nvmStore |-> ##[0:3] txValid)
		else $error("no status after store");
	a_settle_wait: assert property (engineStart && engineOp == dch_pkg::ENG_SETTLE
		|=> !txValid [*3])
		else $error("status before settling");
	c_store: cover property (nvmStore);
	c_settle: cover property (engineStart && engineOp == dch_pkg::ENG_SETTLE);
	c_scan: cover property (scanGo);
endmodule : dch_cmd_handler_asserts

bind dch_cmd_handler dch_cmd_handler_asserts u_chk (.clk_sys(clk_sys),
	.rst_n(rst_n), .scanReq(scanReq), .scanReqValid(scanReqValid),
	.scanGo(scanGo), .engineOp(engineOp), .engineStart(engineStart),
	.nvmStore(nvmStore), .txValid(txValid), .biasSet(biasSet),
	.anodeSelect(anodeSelect), .negativeMode(negativeMode),
	.magnitudeMode(magnitudeMode), .biasIndicator(biasIndicator));

/* File: testbench/dch_engine_model.sv */
// Behavioural analog engine and bias driver
`timescale 1ns/100ps
module dch_engine_model (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        engineStart,
	input wire logic [1:0]  engineOp,
	input wire logic [11:0] biasSet,
	input wire logic        faultReq,
	output logic            engineDone,
	output logic            engineFault,
	output logic [11:0]     biasActual
);
	int cnt;
	// Readback a few volts low, so setpoint echo is caught
	assign biasActual = (biasSet > 12'h003) ? biasSet - 12'h003 : 12'h000;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			engineDone <= 1'b0;
			engineFault <= 1'b0;
			cnt <= 0;
		end else if (engineStart) begin
			engineDone <= 1'b0;
			cnt <= (engineOp == dch_pkg::ENG_CAL) ? 20 : 3;
		end else if (cnt == 1) begin
			engineDone <= 1'b1;
			engineFault <= faultReq;
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule : dch_engine_model

/* File: testbench/tb_dch_cmd_handler.sv */
// Testbench for the detector calibration command handler
`timescale 1ns/100ps
module tb_dch_cmd_handler;
	logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
	logic        optionPin, scanReqValid, scanGo, engineStart, engineDone;
	logic        engineFault, nvmStore, anodeSelect, negativeMode;
	logic        magnitudeMode, biasIndicator, rfDcOn, txValid, txReady;
	logic        faultReq, slv;
	logic [1:0]  scanReq, engineOp;
	logic [2:0]  noiseFloor;
	logic [7:0]  paddr, txData;
	logic [11:0] biasActual, biasSet;
	logic [15:0] offsetMeas, offsetCorr;
	logic [31:0] pwdata, prdata, rd, rxb;
	int          errors, check_count, zeroCnt, massCnt;
	logic [31:0] bad [3];

	dch_cmd_handler u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.optionPin(optionPin), .noiseFloor(noiseFloor), .scanReq(scanReq),
		.scanReqValid(scanReqValid), .scanGo(scanGo), .engineOp(engineOp),
		.engineStart(engineStart), .engineDone(engineDone),
		.engineFault(engineFault), .offsetMeas(offsetMeas),
		.biasActual(biasActual), .nvmStore(nvmStore), .biasSet(biasSet),
		.anodeSelect(anodeSelect), .negativeMode(negativeMode),
		.magnitudeMode(magnitudeMode), .biasIndicator(biasIndicator),
		.rfDcOn(rfDcOn), .offsetCorr(offsetCorr), .txData(txData),
		.txValid(txValid), .txReady(txReady));
	dch_engine_model u_eng (.clk_sys(clk_sys), .rst_n(rst_n),
		.engineStart(engineStart), .engineOp(engineOp), .biasSet(biasSet),
		.faultReq(faultReq), .engineDone(engineDone),
		.engineFault(engineFault), .biasActual(biasActual));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (engineStart === 1'b1 && engineOp === dch_pkg::ENG_ZERO)
			zeroCnt++;
		if (engineStart === 1'b1 && engineOp === dch_pkg::ENG_MASS)
			massCnt++;
	end
	// ==================== Tasks ====================
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1)
			@(posedge clk_sys);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Host waits for each byte before going on
	task automatic rx();
		@(posedge clk_sys);
		while (txValid !== 1'b1)
			@(posedge clk_sys);
		txReady <= 1'b1;
		@(posedge clk_sys);
		rxb = {24'h0, txData};
		txReady <= 1'b0;
	endtask : rx
	function automatic logic [31:0] cw(logic [2:0] op, logic [1:0] f,
		logic [11:0] v, logic ni);
		return {4'h0, v, 9'h000, ni, f, 1'b0, op};
	endfunction : cw
	task automatic cmd(input logic [31:0] w);
		apb(1'b1, dch_pkg::REG_CMD, w);
		rx();
	endtask : cmd
	task automatic tail();
		rx();
		chk("lf", {24'h0, dch_pkg::CH_LF}, rxb);
		rx();
		chk("cr", {24'h0, dch_pkg::CH_CR}, rxb);
	endtask : tail
	task automatic scan(input logic [1:0] k);
		int z, m, n;
		z = zeroCnt;
		m = massCnt;
		n = 0;
		@(posedge clk_sys);
		scanReqValid <= 1'b1;
		scanReq <= k;
		@(posedge clk_sys);
		scanReqValid <= 1'b0;
		while (scanGo !== 1'b1 && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		chk("scan go", 32'h1, {31'h0, scanGo});
		@(negedge clk_sys);
		chk("zero steps", 32'(k != dch_pkg::SCAN_SINGLE), 32'(zeroCnt - z));
		chk("mass steps", 32'(k != dch_pkg::SCAN_SINGLE), 32'(massCnt - m));
	endtask : scan
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out
	// ==================== Sequence ====================
	initial begin
		{rst_n, psel, penable, pwrite, scanReqValid, txReady, faultReq} = '0;
		{paddr, pwdata, scanReq} = '0;
		optionPin = 1'b1;
		noiseFloor = 3'h3;
		offsetMeas = 16'h0123;
		bad = '{cw(3'h3, 2'h1, 12'h9bb, 1'b0), cw(3'h3, 2'h1, 12'h009, 1'b0),
			cw(3'h3, 2'h1, 12'h064, 1'b1)};
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		apb(1'b0, dch_pkg::REG_DET, 32'h0);
		chk("det reset", 32'h0, rd & 32'h3fff);
		scan(dch_pkg::SCAN_ANALOG);
		chk("rf dc on", 32'h1, {31'h0, rfDcOn});
		scan(dch_pkg::SCAN_HIST);
		scan(dch_pkg::SCAN_SINGLE);
		cmd(cw(3'h1, 2'h0, 12'h0, 1'b0));
		chk("cal all", 32'h0, rxb);
		chk("rf dc off", 32'h0, {31'h0, rfDcOn});
		noiseFloor <= 3'h5;
		offsetMeas <= 16'h0456;
		cmd(cw(3'h1, 2'h0, 12'h0, 1'b0));
		apb(1'b1, dch_pkg::REG_OFS_SEL, 32'h3);
		apb(1'b0, dch_pkg::REG_OFS_DATA, 32'h0);
		chk("offset 3", 32'h10123, rd);
		apb(1'b1, dch_pkg::REG_OFS_SEL, 32'h5);
		apb(1'b0, dch_pkg::REG_OFS_DATA, 32'h0);
		chk("offset 5", 32'h10456, rd);
		chk("offset corr", 32'h456, {16'h0, offsetCorr});
		for (int f = 1; f < 4; f++) begin
			cmd(cw(3'h1, 2'(f), 12'h005, 1'b0));
			chk("cal all parm", 32'h4, rxb & 32'h4);
			cmd(cw(3'h2, 2'(f), 12'h005, 1'b0));
			chk("full cal parm", 32'h4, rxb & 32'h4);
		end
		cmd(cw(3'h2, 2'h0, 12'h0, 1'b0));
		chk("full cal", 32'h0, rxb);
		apb(1'b0, dch_pkg::REG_OFS_DATA, 32'h0);
		chk("offset cleared", 32'h0, rd & 32'h10000);
		chk("corr cleared", 32'h0, {16'h0, offsetCorr});
		cmd(cw(3'h3, 2'h2, 12'h0, 1'b0));
		chk("bias default", 32'h0, rxb);
		apb(1'b0, dch_pkg::REG_DET, 32'h0);
		chk("det bias", 32'h7578, rd);
		cmd(cw(3'h3, 2'h3, 12'h0, 1'b0));
		for (int i = 0; i < 4; i++) begin
			if (i > 0)
				rx();
			chk("digit", 32'h30 + (1397 / (10 ** (3 - i))) % 10, rxb);
		end
		tail();
		apb(1'b0, dch_pkg::REG_QUERY, 32'h0);
		chk("query reg", 32'd1397, rd);
		apb(1'b0, dch_pkg::REG_BIAS_ACT, 32'h0);
		chk("bias actual", 32'd1397, rd);
		cmd(cw(3'h3, 2'h1, 12'h0, 1'b0));
		apb(1'b0, dch_pkg::REG_DET, 32'h0);
		chk("det faraday", 32'h0, rd & 32'h3fff);
		cmd(cw(3'h3, 2'h1, 12'h9ba, 1'b0));
		apb(1'b0, dch_pkg::REG_DET, 32'h0);
		chk("det max", 32'h39ba, rd & 32'h3fff);
		foreach (bad[i]) begin
			cmd(bad[i]);
			chk("bias range", 32'h8, rxb & 32'h8);
			apb(1'b0, dch_pkg::REG_MULT_ERR, 32'h0);
			chk("range cause", 32'h4, rd);
		end
		cmd(cw(3'h3, 2'h0, 12'h0, 1'b0));
		chk("bias missing", 32'hc, rxb & 32'hc);
		faultReq <= 1'b1;
		cmd(cw(3'h3, 2'h1, 12'h064, 1'b0));
		faultReq <= 1'b0;
		chk("bias fault", 32'h8, rxb & 32'h8);
		apb(1'b0, dch_pkg::REG_MULT_ERR, 32'h0);
		chk("fault cause", 32'h8, rd);
		cmd(cw(3'h4, 2'h3, 12'h0, 1'b0));
		chk("option", 32'h31, rxb);
		tail();
		cmd(cw(3'h4, 2'h0, 12'h0, 1'b0));
		chk("option form", 32'h4, rxb & 32'h4);
		optionPin <= 1'b0;
		repeat (4) @(posedge clk_sys);
		cmd(cw(3'h3, 2'h2, 12'h0, 1'b0));
		chk("no option", 32'h1, rxb & 32'h1);
		apb(1'b0, dch_pkg::REG_STATUS, 32'h0);
		chk("status reg", 32'h9, rd);
		cmd(cw(3'h4, 2'h3, 12'h0, 1'b0));
		chk("option absent", 32'h30, rxb);
		tail();
		cmd(cw(3'h5, 2'h0, 12'h0, 1'b0));
		chk("bad op", 32'h1, rxb & 32'h1);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h1, {31'h0, slv});
		close_out();
	end
	initial begin
		#2000000;
		errors++;
		close_out();
	end
endmodule : tb_dch_cmd_handler
